/* core/dtdsp_reg_bank.v */
/*
 Byte-wide configuration register bank: constant test value and enable,
 MSB shuffle, switching scheme, serial-port output slew and drive, lane
 receiver power-downs and recovery logic reset control.
 Assumes a serial-port front end on sys_clk_i delivering one-cycle write
 and read strobes with an address and byte; reads answer next cycle.
*/
`timescale 1ns/100ps
`include "dtdsp_consts.vh"

module dtdsp_reg_bank #(
	parameter ELEVEN_BIT_VARIANT = 0
) (
	// Clock, reset, enable
	input  wire                      sys_clk_i,
	input  wire                      sys_rst_i,
	input  wire                      clk_en_i,
	// Register access from serial port
	input  wire [`DTDSP_ADDR_W-1:0]  reg_addr_i,
	input  wire                      reg_wr_i,
	input  wire [`DTDSP_DATA_W-1:0]  reg_wdata_i,
	input  wire                      reg_rd_i,
	output reg  [`DTDSP_DATA_W-1:0]  reg_rdata_o,
	output reg                       reg_rvalid_o,
	// Converter controls
	output reg  [`DTDSP_DATA_W-1:0]  const_test_value_low_o,
	output reg                       const_test_enable_o,
	output reg                       msb_shuffle_o,
	output reg  [1:0]                switching_scheme_o,
	output reg                       scheme_reserved_o,
	// Serial-port pad strength
	output reg  [3:0]                port_output_slew_drive_o,
	// Lane receiver power and reset
	output reg                       lane_rx_global_powerdown_o,
	output reg  [7:0]                lane_rx_individual_powerdown_o,
	output reg                       sync_request_buffer_powerdown_o,
	output reg                       recovery_logic_run_o
);

	reg [`DTDSP_DATA_W-1:0]    dc_low_q;
	reg [`DTDSP_TEST_W-1:0]    digital_test_control_q;
	reg [`DTDSP_DATA_W-1:0]    dec_ctrl_q;
	reg [`DTDSP_SCHEME_W-1:0]  scheme_q;
	reg [`DTDSP_STRENGTH_W-1:0] strength_q;
	reg                        lane_receiver_master_powerdown_q;
	reg [`DTDSP_DATA_W-1:0]    lane_pd_q;
	reg [`DTDSP_MISC_W-1:0]    misc_pd_q;
	reg                        cdr_run_q;
	reg [`DTDSP_DATA_W-1:0]    rdata_d;

	// Writes store each register's stored width; bits above a narrow register's width never latch, full-byte registers keep all eight bits
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			dc_low_q    <= `DTDSP_RST_DC_LOW;
			digital_test_control_q  <= `DTDSP_RST_DIGITAL_TEST_CONTROL;
			dec_ctrl_q  <= `DTDSP_RST_DEC_CTRL;
			scheme_q    <= `DTDSP_RST_SCHEME;
			strength_q  <= `DTDSP_RST_STRENGTH;
			lane_receiver_master_powerdown_q <= `DTDSP_RST_LANE_RECEIVER_MASTER_POWERDOWN;
			lane_pd_q   <= `DTDSP_RST_LANE_PD;
			misc_pd_q   <= `DTDSP_RST_MISC_PD;
			cdr_run_q   <= `DTDSP_RST_CDR_RST;
		end else if (clk_en_i && reg_wr_i) begin
			case (reg_addr_i)
			`DTDSP_OFF_DC_LOW:    dc_low_q <= reg_wdata_i;
			`DTDSP_OFF_DIGITAL_TEST_CONTROL:  digital_test_control_q <= reg_wdata_i[`DTDSP_TEST_W-1:0];
			`DTDSP_OFF_DEC_CTRL:  dec_ctrl_q <= reg_wdata_i;
			`DTDSP_OFF_SCHEME:    scheme_q <= reg_wdata_i[`DTDSP_SCHEME_W-1:0];
			`DTDSP_OFF_STRENGTH:  strength_q <= reg_wdata_i[`DTDSP_STRENGTH_W-1:0];
			`DTDSP_OFF_LANE_RECEIVER_MASTER_POWERDOWN: lane_receiver_master_powerdown_q <= reg_wdata_i[`DTDSP_BIT_LANE_RECEIVER_MASTER_POWERDOWN];
			`DTDSP_OFF_LANE_PD:   lane_pd_q <= reg_wdata_i;
			`DTDSP_OFF_MISC_PD:   misc_pd_q <= reg_wdata_i[`DTDSP_MISC_W-1:0];
			`DTDSP_OFF_CDR_RST:   cdr_run_q <= reg_wdata_i[`DTDSP_BIT_CDR_RUN];
			default: ;
			endcase
		end
	end

	// Read mux; upper reserved read-only bits return zero
	always @* begin
		rdata_d = {`DTDSP_DATA_W{1'b0}};
		case (reg_addr_i)
		`DTDSP_OFF_DC_LOW:    rdata_d = dc_low_q;
		`DTDSP_OFF_DIGITAL_TEST_CONTROL:  rdata_d[`DTDSP_TEST_W-1:0] = digital_test_control_q;
		`DTDSP_OFF_DEC_CTRL:  rdata_d = dec_ctrl_q;
		`DTDSP_OFF_SCHEME:    rdata_d[`DTDSP_SCHEME_W-1:0] = scheme_q;
		`DTDSP_OFF_STRENGTH:  rdata_d[`DTDSP_STRENGTH_W-1:0] = strength_q;
		`DTDSP_OFF_LANE_RECEIVER_MASTER_POWERDOWN: rdata_d[`DTDSP_BIT_LANE_RECEIVER_MASTER_POWERDOWN] = lane_receiver_master_powerdown_q;
		`DTDSP_OFF_LANE_PD:   rdata_d = lane_pd_q;
		`DTDSP_OFF_MISC_PD:   rdata_d[`DTDSP_MISC_W-1:0] = misc_pd_q;
		`DTDSP_OFF_CDR_RST:   rdata_d[`DTDSP_BIT_CDR_RUN] = cdr_run_q;
		default:              rdata_d = {`DTDSP_DATA_W{1'b0}};
		endcase
	end

	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			reg_rdata_o  <= {`DTDSP_DATA_W{1'b0}};
			reg_rvalid_o <= 1'b0;
		end else if (clk_en_i) begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rdata_d;
			end
		end
	end

	// Control outputs registered one cycle behind the bank
	always @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			const_test_value_low_o          <= `DTDSP_RST_DC_LOW;
			const_test_enable_o             <= 1'b0;
			msb_shuffle_o                   <= 1'b0;
			switching_scheme_o              <= `DTDSP_SCHEME_NRZ;
			scheme_reserved_o               <= 1'b0;
			port_output_slew_drive_o        <= `DTDSP_RST_STRENGTH;
			lane_rx_global_powerdown_o      <= `DTDSP_RST_LANE_RECEIVER_MASTER_POWERDOWN;
			lane_rx_individual_powerdown_o  <= `DTDSP_RST_LANE_PD;
			sync_request_buffer_powerdown_o <= 1'b0;
			recovery_logic_run_o            <= `DTDSP_RST_CDR_RST;
		end else if (clk_en_i) begin
			// Variant without test mode keeps value and enable inert
			if (ELEVEN_BIT_VARIANT != 0) begin
				const_test_value_low_o <= `DTDSP_RST_DC_LOW;
				const_test_enable_o    <= 1'b0;
			end else begin
				const_test_value_low_o <= dc_low_q;
				const_test_enable_o    <= digital_test_control_q[`DTDSP_BIT_TEST_EN];
			end
			msb_shuffle_o <= dec_ctrl_q[`DTDSP_BIT_SHUFFLE];
			// Reserved code falls back to NRZ and is flagged
			if (scheme_q == `DTDSP_SCHEME_MIX || scheme_q == `DTDSP_SCHEME_RZ) begin
				switching_scheme_o <= scheme_q;
				scheme_reserved_o  <= 1'b0;
			end else begin
				switching_scheme_o <= `DTDSP_SCHEME_NRZ;
				scheme_reserved_o  <= (scheme_q != `DTDSP_SCHEME_NRZ);
			end
			port_output_slew_drive_o        <= strength_q;
			lane_rx_global_powerdown_o      <= lane_receiver_master_powerdown_q;
			lane_rx_individual_powerdown_o  <= lane_pd_q;
			sync_request_buffer_powerdown_o <= misc_pd_q[`DTDSP_BIT_SYNC_PD];
			recovery_logic_run_o            <= cdr_run_q;
		end
	end

endmodule

/* core/dtdsp_consts.vh */
/*
 Register offsets, field positions and reset values for the converter
 test, decode, serial-port strength and lane receiver power register bank.
 Assumes inclusion by bare name from the bank module.
*/
`ifndef DTDSP_CONSTS_VH
`define DTDSP_CONSTS_VH

`define DTDSP_ADDR_W            12
`define DTDSP_DATA_W            8

`define DTDSP_OFF_DC_LOW        12'h14f
`define DTDSP_OFF_DIGITAL_TEST_CONTROL      12'h150
`define DTDSP_OFF_DEC_CTRL      12'h151
`define DTDSP_OFF_SCHEME        12'h152
`define DTDSP_OFF_STRENGTH      12'h1df
`define DTDSP_OFF_LANE_RECEIVER_MASTER_POWERDOWN     12'h200
`define DTDSP_OFF_LANE_PD       12'h201
`define DTDSP_OFF_MISC_PD       12'h203
`define DTDSP_OFF_CDR_RST       12'h206

`define DTDSP_RST_DC_LOW        8'h00
`define DTDSP_RST_DIGITAL_TEST_CONTROL      2'h0
`define DTDSP_RST_DEC_CTRL      8'h00
`define DTDSP_RST_SCHEME        2'h0
`define DTDSP_RST_STRENGTH      4'hf
`define DTDSP_RST_LANE_RECEIVER_MASTER_POWERDOWN     1'h1
`define DTDSP_RST_LANE_PD       8'h00
`define DTDSP_RST_MISC_PD       2'h0
`define DTDSP_RST_CDR_RST       1'h1

`define DTDSP_BIT_TEST_EN       1
`define DTDSP_BIT_SHUFFLE       2
`define DTDSP_BIT_SYNC_PD       1
`define DTDSP_BIT_LANE_RECEIVER_MASTER_POWERDOWN     0
`define DTDSP_BIT_CDR_RUN       0
`define DTDSP_SCHEME_W          2
`define DTDSP_STRENGTH_W        4
`define DTDSP_MISC_W            2
`define DTDSP_TEST_W            2

`define DTDSP_SCHEME_NRZ        2'h0
`define DTDSP_SCHEME_MIX        2'h1
`define DTDSP_SCHEME_RZ         2'h2

`endif

/* testbench/dtdsp_reg_bank_assertions.sv */
/* Port checker for the register bank; assumes one clock, bound from the bench. */
`timescale 1ns/100ps
module dtdsp_reg_bank_chk (
	input wire        sys_clk_i,
	input wire        sys_rst_i,
	input wire        clk_en_i,
	input wire [11:0] reg_addr_i,
	input wire        reg_wr_i,
	input wire [7:0]  reg_wdata_i,
	input wire [7:0]  const_test_value_low_o,
	input wire        const_test_enable_o,
	input wire        msb_shuffle_o,
	input wire [1:0]  switching_scheme_o,
	input wire        scheme_reserved_o,
	input wire [3:0]  port_output_slew_drive_o,
	input wire        lane_rx_global_powerdown_o,
	input wire [7:0]  lane_rx_individual_powerdown_o,
	input wire        sync_request_buffer_powerdown_o,
	input wire        recovery_logic_run_o
);
	wire wr_en = clk_en_i && reg_wr_i;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Outputs trail the register by one enabled edge
	a_test_low_wr: assert property (wr_en && reg_addr_i == 12'h14f ##1 clk_en_i |=>
		const_test_value_low_o == $past(reg_wdata_i, 2)) else $error("test value");
	a_test_en_wr: assert property (wr_en && reg_addr_i == 12'h150 ##1 clk_en_i |=>
		const_test_enable_o == $past(reg_wdata_i[1], 2)) else $error("test enable");
	a_shuffle_wr: assert property (wr_en && reg_addr_i == 12'h151 ##1 clk_en_i |=>
		msb_shuffle_o == $past(reg_wdata_i[2], 2)) else $error("shuffle");
	a_scheme_wr: assert property (wr_en && reg_addr_i == 12'h152 ##1 clk_en_i |=>
		{scheme_reserved_o, switching_scheme_o} == ($past(reg_wdata_i[1:0], 2) == 2'h3 ?
		3'h4 : {1'b0, $past(reg_wdata_i[1:0], 2)})) else $error("scheme");
	a_strength_wr: assert property (wr_en && reg_addr_i == 12'h1df ##1 clk_en_i |=>
		port_output_slew_drive_o == $past(reg_wdata_i[3:0], 2)) else $error("strength");
	a_lane_receiver_master_powerdown_wr: assert property (wr_en && reg_addr_i == 12'h200 ##1 clk_en_i |=>
		lane_rx_global_powerdown_o == $past(reg_wdata_i[0], 2)) else $error("lane_receiver_master_powerdown");
	a_lane_pd_wr: assert property (wr_en && reg_addr_i == 12'h201 ##1 clk_en_i |=>
		lane_rx_individual_powerdown_o == $past(reg_wdata_i, 2)) else $error("lane pd");
	a_sync_pd_wr: assert property (wr_en && reg_addr_i == 12'h203 ##1 clk_en_i |=>
		sync_request_buffer_powerdown_o == $past(reg_wdata_i[1], 2)) else $error("sync pd");
	a_run_wr: assert property (wr_en && reg_addr_i == 12'h206 ##1 clk_en_i |=>
		recovery_logic_run_o == $past(reg_wdata_i[0], 2)) else $error("recovery run");
endmodule

/* testbench/dtdsp_reg_bank_tb.sv */
/* Register bank bench: reset readback, write and readback table, scheme codes, unmapped. */
`timescale 1ns/100ps
module dtdsp_reg_bank_tb;
	logic        sys_clk_i, reg_rvalid_o, const_test_enable_o, msb_shuffle_o, scheme_reserved_o;
	logic        sys_rst_i = 1'b1, clk_en_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic        lane_rx_global_powerdown_o, sync_request_buffer_powerdown_o, recovery_logic_run_o;
	logic [11:0] reg_addr_i = 12'h000;
	logic [7:0]  reg_wdata_i = 8'h00, reg_rdata_o, const_test_value_low_o;
	logic [7:0]  lane_rx_individual_powerdown_o;
	logic [3:0]  port_output_slew_drive_o;
	logic [1:0]  switching_scheme_o;
	int          num_errors = 0;
	int          num_checks = 0;
	// Address, write byte, readback after write, reset value
	logic [35:0] rows [9] = '{36'h14fffff00, 36'h150ff0300, 36'h151ffff00, 36'h152ff0300,
		36'h1dfa5050f, 36'h200fe0001, 36'h2015a5a00, 36'h203ff0300, 36'h206fe0001};
	dtdsp_reg_bank #(.ELEVEN_BIT_VARIANT(0)) dut_u (.*);
	task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string name);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Answer lands on the same edge that takes the strobe
	task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({reg_rvalid_o, reg_rdata_o}, {1'b1, e}, "read answer");
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		repeat (3000) @(posedge sys_clk_i);
		num_errors++;
		end_sim;
	end
	initial begin
		repeat (4) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		foreach (rows[i]) begin
			rd_reg(rows[i][35:24], rows[i][7:0]);
			wr_reg(rows[i][35:24], rows[i][23:16]);
			rd_reg(rows[i][35:24], rows[i][15:8]);
		end
		$display("table test done");
		for (int k = 0; k < 4; k++) begin
			wr_reg(12'h152, 8'(k));
			rd_reg(12'h152, 8'(k));
			chk({6'h00, scheme_reserved_o, switching_scheme_o}, (k == 3) ? 9'h004 : 9'(k), "scheme out");
		end
		$display("scheme test done");
		wr_reg(12'h300, 8'hff);
		rd_reg(12'h300, 8'h00);
		$display("unmapped test done");
		chk({1'b0, const_test_value_low_o}, 9'h0ff, "test value out");
		chk({8'h00, const_test_enable_o}, 9'h001, "test enable out");
		chk({8'h00, msb_shuffle_o}, 9'h001, "shuffle out");
		chk({5'h00, port_output_slew_drive_o}, 9'h005, "slew drive out");
		chk({8'h00, lane_rx_global_powerdown_o}, 9'h000, "lane_receiver_master_powerdown out");
		chk({1'b0, lane_rx_individual_powerdown_o}, 9'h05a, "lane pd out");
		chk({8'h00, sync_request_buffer_powerdown_o}, 9'h001, "sync pd out");
		chk({8'h00, recovery_logic_run_o}, 9'h000, "run out");
		$display("output test done");
		// Frozen enable must swallow the write strobe
		@(posedge sys_clk_i);
		clk_en_i <= 1'b0;
		wr_reg(12'h201, 8'h3c);
		@(posedge sys_clk_i);
		clk_en_i <= 1'b1;
		rd_reg(12'h201, 8'h5a);
		$display("enable test done");
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b1;
		@(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk({5'h00, port_output_slew_drive_o}, 9'h00f, "slew drive reset");
		chk({8'h00, lane_rx_global_powerdown_o}, 9'h001, "lane_receiver_master_powerdown reset");
		chk({1'b0, lane_rx_individual_powerdown_o}, 9'h000, "lane pd reset");
		chk({8'h00, recovery_logic_run_o}, 9'h001, "run reset");
		rd_reg(12'h1df, 8'h0f);
		$display("mid-run reset test done");
		end_sim;
	end
endmodule
bind dtdsp_reg_bank dtdsp_reg_bank_chk chk_u (.*);
